//--- ppf_port.v
`include "ppf_map.vh"
// Purpose: device side of the parallel programming port with fuse, lock,
//   signature and calibration storage and small flash/eeprom arrays
// Assumes: pins arrive asynchronous and are synchronised to clock_i
// Notes: data bus output enable is low while the device drives it
module ppf_port #(
  parameter [7:0] SIG0 = 8'h5A,
  parameter [7:0] SIG1 = 8'h3C,
  parameter [7:0] SIG2 = 8'h01,
  parameter [7:0] CAL_BYTE = 8'h80,
  parameter BUSY_CYCLES = `PPF_BUSY_CYCLES
) (
  input wire clock_i,
  input wire rst_i,
  input wire prog_mode_i,
  input wire serial_mode_i,
  input wire crystal_in_strobe_i,
  input wire pulse_action_bit0_i,
  input wire pulse_action_bit1_i,
  input wire byte_sel_low_high_i,
  input wire store_pulse_n_i,
  input wire output_enable_n_i,
  input wire [7:0] data_i,
  output reg [7:0] data_o,
  output reg data_oe_n_o,
  output reg ready_busy_o,
  output reg [7:0] fuse_ext_work_o,
  output reg [7:0] fuse_high_work_o,
  output reg [7:0] fuse_low_work_o,
  output reg keep_eeprom_now_o,
  output reg [7:0] rc_osc_trim_reg_o
);
  // SIG0..SIG2 and CAL_BYTE defaults are arbitrary values
  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  reg [6:0] s1_reg;
  reg [6:0] s2_reg;
  reg [7:0] d1_reg;
  reg [7:0] d2_reg;
  reg [1:0] pm_reg;
  reg strobe_d_reg;
  reg store_d_reg;
  reg pagel_d_reg;
  always @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      // Idle pin levels: output enable and store pulse high, action bits and crystal strobe low
      s1_reg <= 7'h30;
      s2_reg <= 7'h30;
      d1_reg <= 8'h00;
      d2_reg <= 8'h00;
      pm_reg <= 2'b00;
      strobe_d_reg <= 1'b0;
      store_d_reg <= 1'b1;
      pagel_d_reg <= 1'b0;
    end
    else
    begin
      s1_reg <= {serial_mode_i, output_enable_n_i, store_pulse_n_i, byte_sel_low_high_i,
                 pulse_action_bit1_i, pulse_action_bit0_i, crystal_in_strobe_i};
      s2_reg <= s1_reg;
      d1_reg <= data_i;
      d2_reg <= d1_reg;
      pm_reg <= {pm_reg[0], prog_mode_i};
      strobe_d_reg <= s2_reg[0];
      store_d_reg <= s2_reg[4];
      pagel_d_reg <= s2_reg[3];
    end
  end
  wire strobe_s = s2_reg[0];
  wire [1:0] act_s = s2_reg[2:1];
  wire bs1_s = s2_reg[3];
  wire store_n_s = s2_reg[4];
  wire oe_n_s = s2_reg[5];
  wire serial_s = s2_reg[6];
  wire prog_s = pm_reg[1];
  // Edge detectors compare against the previous synchronised level
  wire strobe_rise = strobe_s && !strobe_d_reg;
  wire store_fall = !store_n_s && store_d_reg;
  wire pagel_rise = bs1_s && !pagel_d_reg && (act_s == 2'b11);
  // ---------------------------------------------------------------
  // State and storage
  // ---------------------------------------------------------------
  reg [7:0] cmd_reg;
  reg [7:0] addr_lo_reg;
  reg [7:0] addr_hi_reg;
  reg [7:0] dat_lo_reg;
  reg [7:0] dat_hi_reg;
  reg [7:0] fuse_extended_byte_reg;
  reg [7:0] fuse_high_byte_reg;
  reg [7:0] fuse_low_byte_reg;
  reg [1:0] lock_reg;
  reg [15:0] flash_reg [0:`PPF_FLASH_WORDS-1];
  reg [7:0] ee_reg [0:`PPF_EE_BYTES-1];
  reg [15:0] busy_cnt_reg;
  reg prog_d_reg;
  reg erase_run_reg;
  reg flash_run_reg;
  reg ee_run_reg;
  reg [3:0] ld_idx_reg;
  reg flush_reg;
  reg boot_reg;
  wire [9:0] word_addr = {addr_hi_reg[1:0], addr_lo_reg};
  wire [5:0] page_idx = word_addr[9:4];
  wire [6:0] eeprom_byte_addr = addr_lo_reg[6:0];
  wire [4:0] ee_page_idx = eeprom_byte_addr[6:2];
  wire busy = (busy_cnt_reg != 16'h0000);
  wire write_cmd = (cmd_reg == `PPF_CMD_ERASE) || (cmd_reg == `PPF_CMD_WR_FUSE) ||
                   (cmd_reg == `PPF_CMD_WR_LOCK) || (cmd_reg == `PPF_CMD_WR_FLASH) ||
                   (cmd_reg == `PPF_CMD_WR_EE);
  // ---------------------------------------------------------------
  // Page buffer
  // ---------------------------------------------------------------
  // Page data goes through the FIFO; drained while the page program runs
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [15:0] fifo_out_data;
  wire fifo_push = prog_s && pagel_rise && !busy &&
                   ((cmd_reg == `PPF_CMD_WR_FLASH) || (cmd_reg == `PPF_CMD_WR_EE));
  // A flush pops without writing, so data left from an abandoned page is dropped
  wire fifo_pop = (flash_run_reg || ee_run_reg || flush_reg) && fifo_out_valid;
  ppf_fifo #(.WIDTH(16), .DEPTH(32), .AW(5)) u_fifo (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .in_valid_i(fifo_push),
    .in_ready_o(fifo_in_ready),
    .in_data_i({dat_hi_reg, dat_lo_reg}),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(fifo_pop),
    .out_data_o(fifo_out_data)
  );
  reg [4:0] load_ofs_reg [0:31];
  reg [4:0] wr_ptr_reg;
  reg [4:0] rd_ptr_reg;
  // ---------------------------------------------------------------
  // Array writes
  // ---------------------------------------------------------------
  integer i;
  always @(posedge clock_i)
  begin
    // Erase fills flash with the blank value once the busy time is over, and eeprom too only while the high fuse keep bit is 1
    if (erase_run_reg && !busy)
    begin
      for (i = 0; i < `PPF_FLASH_WORDS; i = i + 1)
        flash_reg[i] <= 16'hFFFF;
      if (fuse_high_byte_reg[`PPF_HIGH_KEEP_EE_BIT])
        for (i = 0; i < `PPF_EE_BYTES; i = i + 1)
          ee_reg[i] <= 8'hFF;
    end
    if (fifo_push && fifo_in_ready)
      load_ofs_reg[wr_ptr_reg] <= (cmd_reg == `PPF_CMD_WR_FLASH) ? {1'b0, word_addr[3:0]}
                                                                 : {3'b000, eeprom_byte_addr[1:0]};
    if (fifo_pop && flash_run_reg)
      flash_reg[{page_idx, load_ofs_reg[rd_ptr_reg][3:0]}] <= fifo_out_data;
    if (fifo_pop && ee_run_reg)
      ee_reg[{ee_page_idx, load_ofs_reg[rd_ptr_reg][1:0]}] <= fifo_out_data[7:0];
  end
  // ---------------------------------------------------------------
  // Control
  // ---------------------------------------------------------------
  always @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cmd_reg <= `PPF_CMD_NOP;
      addr_lo_reg <= 8'h00;
      addr_hi_reg <= 8'h00;
      dat_lo_reg <= 8'h00;
      dat_hi_reg <= 8'h00;
      fuse_extended_byte_reg <= `PPF_FUSE_EXT_RST;
      fuse_high_byte_reg <= `PPF_FUSE_HIGH_RST;
      fuse_low_byte_reg <= `PPF_FUSE_LOW_RST;
      lock_reg <= `PPF_LOCK_RST;
      busy_cnt_reg <= 16'h0000;
      prog_d_reg <= 1'b0;
      erase_run_reg <= 1'b0;
      flash_run_reg <= 1'b0;
      ee_run_reg <= 1'b0;
      wr_ptr_reg <= 5'h00;
      rd_ptr_reg <= 5'h00;
      ld_idx_reg <= 4'h0;
      flush_reg <= 1'b0;
    end
    else
    begin
      prog_d_reg <= prog_s;
      if (fifo_push && fifo_in_ready)
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (fifo_pop)
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      if (prog_s && strobe_rise && !busy)
      begin
        // Unchanged fields persist until reloaded
        case (act_s)
          `PPF_ACT_ADDR:
            if (bs1_s)
              addr_hi_reg <= d2_reg;
            else
              addr_lo_reg <= d2_reg;
          `PPF_ACT_DATA:
            if (bs1_s)
              dat_hi_reg <= d2_reg;
            else
              dat_lo_reg <= d2_reg;
          `PPF_ACT_CMD:
            begin
              cmd_reg <= d2_reg;
              if (d2_reg == `PPF_CMD_NOP)
              begin
                flash_run_reg <= 1'b0;
                ee_run_reg <= 1'b0;
                flush_reg <= 1'b1;
              end
            end
          default:
            ld_idx_reg <= ld_idx_reg;
        endcase
      end
      if (busy)
        busy_cnt_reg <= busy_cnt_reg - 1'b1;
      else
      begin
        erase_run_reg <= 1'b0;
        // Locks return to unprogrammed in the same cycle the arrays are erased; fuses stay
        if (erase_run_reg)
          lock_reg <= `PPF_LOCK_RST;
        if (!fifo_out_valid)
        begin
          flash_run_reg <= 1'b0;
          ee_run_reg <= 1'b0;
          flush_reg <= 1'b0;
        end
      end
      if (prog_s && store_fall && !busy && write_cmd)
      begin
        busy_cnt_reg <= BUSY_CYCLES[15:0];
        case (cmd_reg)
          `PPF_CMD_ERASE:
            begin
              erase_run_reg <= 1'b1;
            end
          `PPF_CMD_WR_FUSE:
            if (lock_reg[0])
            begin
              if (act_s[1])
                fuse_extended_byte_reg <= {7'h7F, dat_lo_reg[0]};
              else if (bs1_s)
              begin
                if (serial_s)
                  fuse_high_byte_reg <= {dat_lo_reg[7:6], fuse_high_byte_reg[5], dat_lo_reg[4:0]};
                else
                  fuse_high_byte_reg <= dat_lo_reg;
              end
              else
                fuse_low_byte_reg <= dat_lo_reg;
            end
          `PPF_CMD_WR_LOCK:
            lock_reg <= lock_reg & dat_lo_reg[1:0];
          `PPF_CMD_WR_FLASH:
            flash_run_reg <= 1'b1;
          default:
            ee_run_reg <= 1'b1;
        endcase
      end
    end
  end
  // ---------------------------------------------------------------
  // Working latches, trim and read path
  // ---------------------------------------------------------------
  reg [7:0] rd_byte;
  reg rd_ok;
  always @*
  begin
    rd_byte = 8'hFF;
    rd_ok = 1'b1;
    case (cmd_reg)
      `PPF_CMD_RD_SIG:
        if (bs1_s)
          rd_byte = CAL_BYTE;
        else if (addr_lo_reg[1:0] == 2'b00)
          rd_byte = SIG0;
        else if (addr_lo_reg[1:0] == 2'b01)
          rd_byte = SIG1;
        else
          rd_byte = SIG2;
      `PPF_CMD_RD_FUSE:
        if (act_s[1] && bs1_s)
          rd_byte = fuse_high_byte_reg;
        else if (act_s[1])
          rd_byte = fuse_extended_byte_reg;
        else if (bs1_s)
          rd_byte = {6'h3F, lock_reg};
        else
          rd_byte = fuse_low_byte_reg;
      `PPF_CMD_RD_FLASH:
        if (lock_reg[1] == 1'b0)
          rd_byte = 8'hFF;
        else if (bs1_s)
          rd_byte = flash_reg[word_addr][15:8];
        else
          rd_byte = flash_reg[word_addr][7:0];
      `PPF_CMD_RD_EE:
        rd_byte = (lock_reg[1] == 1'b0) ? 8'hFF : ee_reg[eeprom_byte_addr];
      default:
        rd_ok = 1'b0;
    endcase
    if (serial_s && cmd_reg == `PPF_CMD_RD_FUSE && bs1_s && act_s[1])
      rd_byte[`PPF_HIGH_SER_ALLOW_BIT] = 1'b1;
  end
  // ---------------------------------------------------------------
  // Registered outputs
  // ---------------------------------------------------------------
  always @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      data_o <= 8'h00;
      data_oe_n_o <= 1'b1;
      ready_busy_o <= 1'b0;
      fuse_ext_work_o <= `PPF_FUSE_EXT_RST;
      fuse_high_work_o <= `PPF_FUSE_HIGH_RST;
      fuse_low_work_o <= `PPF_FUSE_LOW_RST;
      keep_eeprom_now_o <= 1'b1;
      // Trim takes the calibration byte during every reset
      rc_osc_trim_reg_o <= CAL_BYTE;
      boot_reg <= 1'b1;
    end
    else
    begin
      boot_reg <= 1'b0;
      // Latch on entering or leaving programming, and once after power-up in normal mode
      if ((prog_s != prog_d_reg) || (boot_reg && !prog_s))
      begin
        fuse_ext_work_o <= fuse_extended_byte_reg;
        fuse_high_work_o <= fuse_high_byte_reg;
        fuse_low_work_o <= fuse_low_byte_reg;
      end
      keep_eeprom_now_o <= fuse_high_byte_reg[`PPF_HIGH_KEEP_EE_BIT];
      ready_busy_o <= !busy;
      data_o <= rd_byte;
      data_oe_n_o <= !(prog_s && !oe_n_s && rd_ok);
    end
  end
endmodule

//--- ppf_map.vh
// Purpose: constants for the parallel programming and fuse port
// Assumes: 50 MHz clock_i, 20 ns period
// Notes: fuse bits read 0 when programmed, 1 when unprogrammed
`ifndef PPF_MAP_VH
`define PPF_MAP_VH
`define PPF_CMD_NOP 8'h00
`define PPF_CMD_ERASE 8'h80
`define PPF_CMD_WR_FUSE 8'h40
`define PPF_CMD_WR_LOCK 8'h20
`define PPF_CMD_WR_FLASH 8'h10
`define PPF_CMD_WR_EE 8'h11
`define PPF_CMD_RD_SIG 8'h08
`define PPF_CMD_RD_FUSE 8'h04
`define PPF_CMD_RD_FLASH 8'h02
`define PPF_CMD_RD_EE 8'h03
`define PPF_ACT_ADDR 2'b00
`define PPF_ACT_DATA 2'b01
`define PPF_ACT_CMD 2'b10
`define PPF_FUSE_EXT_RST 8'hFF
`define PPF_FUSE_HIGH_RST 8'hDF
`define PPF_FUSE_LOW_RST 8'h62
`define PPF_LOCK_RST 2'b11
`define PPF_HIGH_KEEP_EE_BIT 6
`define PPF_HIGH_SER_ALLOW_BIT 5
`define PPF_CLK_SRC_RC 4'h2
`define PPF_FLASH_WORDS 1024
`define PPF_FLASH_PAGE_WORDS 16
`define PPF_EE_BYTES 128
`define PPF_EE_PAGE_BYTES 4
`define PPF_BUSY_CYCLES 16
`endif

//--- ppf_fifo.v
// Purpose: small synchronous FIFO for page-load data
// Assumes: one clock, asynchronous active-high reset
// Notes: storage in flip-flops, index addressed
module ppf_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 32,
  parameter AW = 5
) (
  input wire clock_i,
  input wire rst_i,
  input wire in_valid_i,
  output wire in_ready_o,
  input wire [WIDTH-1:0] in_data_i,
  output wire out_valid_o,
  input wire out_ready_i,
  output wire [WIDTH-1:0] out_data_o
);
  reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
  reg [AW-1:0] wr_reg;
  reg [AW-1:0] rd_reg;
  reg [AW:0] cnt_reg;
  wire push;
  wire pop;
  assign in_ready_o = (cnt_reg != DEPTH);
  assign out_valid_o = (cnt_reg != 0);
  assign out_data_o = mem_reg[rd_reg];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  always @(posedge clock_i)
  begin
    if (push)
      mem_reg[wr_reg] <= in_data_i;
  end
  always @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      wr_reg <= {AW{1'b0}};
      rd_reg <= {AW{1'b0}};
      cnt_reg <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
        wr_reg <= wr_reg + 1'b1;
      if (pop)
        rd_reg <= rd_reg + 1'b1;
      if (push && !pop)
        cnt_reg <= cnt_reg + 1'b1;
      else if (pop && !push)
        cnt_reg <= cnt_reg - 1'b1;
    end
  end
endmodule

//--- ppf_port_monitor.sv
// Purpose: assertions on the pins of the programming port
// Assumes: one clock, reset active high
// Notes: follows the loaded command from the pins
module ppf_port_monitor #(
  parameter [7:0] CAL_BYTE = 8'h80
) (
  input wire clock_i,
  input wire rst_i,
  input wire prog_mode_i,
  input wire crystal_in_strobe_i,
  input wire pulse_action_bit0_i,
  input wire pulse_action_bit1_i,
  input wire store_pulse_n_i,
  input wire output_enable_n_i,
  input wire [7:0] data_i,
  input wire data_oe_n_o,
  input wire ready_busy_o,
  input wire [7:0] fuse_ext_work_o,
  input wire [7:0] fuse_high_work_o,
  input wire [7:0] fuse_low_work_o,
  input wire [7:0] rc_osc_trim_reg_o
);
  logic xs_q;
  logic [7:0] cmd_q;
  logic rd_c;
  logic wr_c;
  assign rd_c = cmd_q inside {8'h08, 8'h04, 8'h02, 8'h03};
  assign wr_c = cmd_q inside {8'h80, 8'h40, 8'h20, 8'h10, 8'h11};
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  // ------------------------------
  // Command seen on the pins
  // ------------------------------
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      xs_q <= 1'b0;
      cmd_q <= 8'h00;
    end
    else
    begin
      xs_q <= crystal_in_strobe_i;
      if (crystal_in_strobe_i && !xs_q && {pulse_action_bit1_i, pulse_action_bit0_i} == 2'b10)
        cmd_q <= data_i;
    end
  end
  a_reset_fuse_defaults:
  assert property ($fell(rst_i) |-> fuse_low_work_o == 8'h62 && fuse_high_work_o == 8'hDF
    && fuse_ext_work_o == 8'hFF) else $error("fuse defaults wrong");
  a_ext_spare_bits:
  assert property (fuse_ext_work_o[7:1] == 7'h7F) else $error("spare extended bits wrong");
  a_trim_from_cal:
  assert property (rc_osc_trim_reg_o == CAL_BYTE) else $error("trim not calibration byte");
  a_ready_after_reset:
  assert property ($fell(rst_i) |-> ##[0:2] ready_busy_o) else $error("not ready after reset");
  a_store_sets_busy:
  assert property ($fell(store_pulse_n_i) && prog_mode_i && ready_busy_o && wr_c |-> ##[1:8] !ready_busy_o)
    else $error("store did not start busy");
  a_busy_run_length:
  assert property ($fell(ready_busy_o) |-> ##12 !ready_busy_o ##[1:6] ready_busy_o)
    else $error("busy length wrong");
  a_idle_bus_free:
  assert property (output_enable_n_i [*6] |-> data_oe_n_o) else $error("bus driven without enable");
  a_unlisted_bus_free:
  assert property ((!rd_c) [*6] |-> data_oe_n_o) else $error("bus driven without read code");
  a_read_drives_bus:
  assert property ((!output_enable_n_i && rd_c && prog_mode_i) [*6] |-> !data_oe_n_o)
    else $error("read did not drive bus");
  a_fuses_held_in_prog:
  assert property (prog_mode_i && $past(prog_mode_i, 6) |-> $stable(fuse_low_work_o) && $stable(fuse_high_work_o))
    else $error("working fuses moved in programming");
endmodule

bind ppf_port ppf_port_monitor #(.CAL_BYTE(CAL_BYTE)) i_ppf_port_monitor (.clock_i, .rst_i, .prog_mode_i,
  .crystal_in_strobe_i, .pulse_action_bit0_i, .pulse_action_bit1_i, .store_pulse_n_i, .output_enable_n_i,
  .data_i, .data_oe_n_o, .ready_busy_o, .fuse_ext_work_o, .fuse_high_work_o, .fuse_low_work_o,
  .rc_osc_trim_reg_o);

//--- ppf_pgm.sv
// Purpose: parallel programmer that drives the device pins
// Assumes: pins change at the falling clock edge
// Notes: shows an inverted pattern on the bus while reading
module ppf_pgm (
  input wire logic clock_i,
  input wire logic ready_busy_i,
  input wire logic [7:0] bus_i,
  output logic strobe_o,
  output logic act0_o,
  output logic act1_o,
  output logic bs_o,
  output logic store_n_o,
  output logic oe_n_o,
  output logic [7:0] data_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    strobe_o = 1'b0;
    act0_o = 1'b0;
    act1_o = 1'b0;
    bs_o = 1'b0;
    store_n_o = 1'b0;
    oe_n_o = 1'b1;
    data_o = 8'h00;
  end
  task automatic hold();
    repeat (13) @(negedge clock_i);
  endtask
  task automatic ld(input logic [1:0] act, input logic bs, input logic [7:0] d);
    store_n_o = 1'b1;
    {act1_o, act0_o} = act;
    bs_o = bs;
    data_o = d;
    hold();
    strobe_o = 1'b1;
    hold();
    strobe_o = 1'b0;
    hold();
  endtask
  task automatic pagel();
    bs_o = 1'b0;
    {act1_o, act0_o} = 2'b11;
    hold();
    bs_o = 1'b1;
    hold();
    bs_o = 1'b0;
    hold();
  endtask
  task automatic wr(input logic bs, input logic b1, output logic busy);
    int n;
    n = 0;
    busy = 1'b0;
    {act1_o, act0_o} = {b1, 1'b0};
    bs_o = bs;
    hold();
    store_n_o = 1'b0;
    repeat (13)
    begin
      @(negedge clock_i);
      if (ready_busy_i === 1'b0)
        busy = 1'b1;
    end
    store_n_o = 1'b1;
    while (ready_busy_i !== 1'b1 && n < 200)
    begin
      @(negedge clock_i);
      n++;
    end
    hold();
  endtask
  task automatic rd(input logic bs, input logic b1, output logic [7:0] q);
    {act1_o, act0_o} = {b1, 1'b0};
    bs_o = bs;
    hold();
    oe_n_o = 1'b0;
    data_o = ~data_o;
    hold();
    q = bus_i;
    oe_n_o = 1'b1;
    hold();
  endtask
endmodule

//--- testbench.sv
// Purpose: self-checking bench for the programming port
// Assumes: 50 MHz clock, programmer model drives the pins
// Notes: expectations follow the fuse map and command codes
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] S0 = 8'hA1; // Arbitrary signature values
  localparam logic [7:0] S1 = 8'hB2;
  localparam logic [7:0] S2 = 8'hC3;
  localparam logic [7:0] CAL = 8'h6D; // Arbitrary calibration value
  localparam logic [7:0] SIG [3] = '{S0, S1, S2};
  logic clk, rst = 1'b1, prog = 1'b0, ser = 1'b0;
  logic xs, a0, a1, bs, wr_n, oe_n, rb, doe_n, keep, b;
  logic [7:0] pd, dq, bus, q, fe, fh, fl, trim;
  int error_cnt = 0;
  int samples_checked = 0;
  int cyc = 0;
  assign bus = doe_n ? pd : dq;
  ppf_port #(.SIG0(S0), .SIG1(S1), .SIG2(S2), .CAL_BYTE(CAL)) i_ppf_port (.clock_i(clk), .rst_i(rst),
    .prog_mode_i(prog), .serial_mode_i(ser), .crystal_in_strobe_i(xs), .pulse_action_bit0_i(a0),
    .pulse_action_bit1_i(a1), .byte_sel_low_high_i(bs), .store_pulse_n_i(wr_n), .output_enable_n_i(oe_n),
    .data_i(bus), .data_o(dq), .data_oe_n_o(doe_n), .ready_busy_o(rb), .fuse_ext_work_o(fe),
    .fuse_high_work_o(fh), .fuse_low_work_o(fl), .keep_eeprom_now_o(keep), .rc_osc_trim_reg_o(trim));
  ppf_pgm i_ppf_pgm (.clock_i(clk), .ready_busy_i(rb), .bus_i(bus), .strobe_o(xs), .act0_o(a0),
    .act1_o(a1), .bs_o(bs), .store_n_o(wr_n), .oe_n_o(oe_n), .data_o(pd));
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmd(input logic [7:0] c);
    i_ppf_pgm.ld(2'b10, 1'b0, c);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 12000)
    begin
      error_cnt++;
      results();
    end
  end
  // ------------------------------
  // Test sequence
  // ------------------------------
  initial
  begin
    repeat (4) @(negedge clk);
    rst = 1'b0;
    repeat (6) @(negedge clk);
    chk(fl, 8'h62);
    chk(fh, 8'hDF);
    chk(fe, 8'hFF);
    chk(trim, CAL);
    chk({7'h00, rb}, 8'h01);
    $display("test reset done");
    prog = 1'b1;
    repeat (20) @(negedge clk);
    cmd(8'h08);
    for (int i = 0; i < 3; i++)
    begin
      i_ppf_pgm.ld(2'b00, 1'b0, 8'(i));
      i_ppf_pgm.rd(1'b0, 1'b0, q);
      chk(q, SIG[i]);
    end
    i_ppf_pgm.ld(2'b00, 1'b0, 8'h00);
    i_ppf_pgm.rd(1'b1, 1'b0, q);
    chk(q, CAL);
    $display("test signature done");
    cmd(8'h10);
    i_ppf_pgm.ld(2'b00, 1'b0, 8'h13);
    i_ppf_pgm.ld(2'b01, 1'b0, 8'hA5);
    i_ppf_pgm.ld(2'b01, 1'b1, 8'h5A);
    i_ppf_pgm.pagel();
    i_ppf_pgm.ld(2'b00, 1'b1, 8'h00);
    i_ppf_pgm.wr(1'b0, 1'b0, b);
    chk({7'h00, b}, 8'h01);
    cmd(8'h00);
    cmd(8'h02);
    i_ppf_pgm.rd(1'b0, 1'b0, q);
    chk(q, 8'hA5);
    i_ppf_pgm.rd(1'b1, 1'b0, q);
    chk(q, 8'h5A);
    cmd(8'h11);
    i_ppf_pgm.ld(2'b00, 1'b0, 8'h45);
    i_ppf_pgm.ld(2'b01, 1'b0, 8'h3C);
    i_ppf_pgm.pagel();
    i_ppf_pgm.wr(1'b0, 1'b0, b);
    cmd(8'h03);
    i_ppf_pgm.rd(1'b0, 1'b0, q);
    chk(q, 8'h3C);
    cmd(8'h11);
    i_ppf_pgm.ld(2'b01, 1'b0, 8'h77);
    i_ppf_pgm.pagel();
    cmd(8'h00);
    cmd(8'h11);
    i_ppf_pgm.wr(1'b0, 1'b0, b);
    cmd(8'h03);
    i_ppf_pgm.rd(1'b0, 1'b0, q);
    chk(q, 8'h3C);
    $display("test memories done");
    cmd(8'h40);
    i_ppf_pgm.ld(2'b01, 1'b0, 8'h00);
    i_ppf_pgm.wr(1'b0, 1'b0, b);
    chk(fl, 8'h62);
    cmd(8'h04);
    i_ppf_pgm.rd(1'b0, 1'b0, q);
    chk(q, 8'h00);
    cmd(8'h40);
    i_ppf_pgm.ld(2'b01, 1'b0, 8'h9F);
    i_ppf_pgm.wr(1'b1, 1'b0, b);
    chk({7'h00, keep}, 8'h00);
    chk(fh, 8'hDF);
    cmd(8'h55);
    i_ppf_pgm.rd(1'b0, 1'b0, q);
    chk(q, 8'hAA);
    ser = 1'b1;
    cmd(8'h40);
    i_ppf_pgm.ld(2'b01, 1'b0, 8'hFF);
    i_ppf_pgm.wr(1'b1, 1'b0, b);
    ser = 1'b0;
    cmd(8'h04);
    i_ppf_pgm.rd(1'b1, 1'b1, q);
    chk(q, 8'hDF);
    $display("test fuses done");
    cmd(8'h80);
    i_ppf_pgm.wr(1'b0, 1'b0, b);
    chk({7'h00, b}, 8'h01);
    cmd(8'h04);
    i_ppf_pgm.rd(1'b0, 1'b0, q);
    chk(q, 8'h00);
    cmd(8'h20);
    i_ppf_pgm.ld(2'b01, 1'b0, 8'hFE);
    i_ppf_pgm.wr(1'b0, 1'b0, b);
    cmd(8'h40);
    i_ppf_pgm.ld(2'b01, 1'b0, 8'hFF);
    i_ppf_pgm.wr(1'b0, 1'b0, b);
    cmd(8'h04);
    i_ppf_pgm.rd(1'b0, 1'b0, q);
    chk(q, 8'h00);
    cmd(8'h08);
    i_ppf_pgm.ld(2'b00, 1'b0, 8'h01);
    i_ppf_pgm.rd(1'b0, 1'b0, q);
    chk(q, S1);
    prog = 1'b0;
    repeat (20) @(negedge clk);
    chk(fl, 8'h00);
    $display("test erase and lock done");
    results();
  end
endmodule
